// ### fhc_pkg.sv
// Package of constants for the flash host controller, plus its two-stage pin synchroniser.
`default_nettype none

package fhc_pkg;
   // Register byte offsets on the APB side.
   localparam logic [7:0] FHC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] FHC_ADDR_OFS   = 8'h04;
   localparam logic [7:0] FHC_WDATA_OFS  = 8'h08;
   localparam logic [7:0] FHC_RDATA_OFS  = 8'h0c;
   localparam logic [7:0] FHC_STATUS_OFS = 8'h10;
   localparam logic [7:0] FHC_ISTAT_OFS  = 8'h14;
   localparam logic [7:0] FHC_IMASK_OFS  = 8'h18;

   // Control register fields.
   localparam int FHC_CTRL_GO     = 0;
   localparam int FHC_CTRL_OP_LSB = 1;
   localparam int FHC_CTRL_PROT   = 4;
   localparam int FHC_CTRL_UNPROT = 5;
   localparam int FHC_CTRL_VID    = 6;

   // Interrupt status bits.
   localparam int FHC_IRQ_DONE = 0;
   localparam int FHC_IRQ_FAIL = 1;
   localparam int FHC_IRQ_TMO  = 2;
   localparam int FHC_IRQ_W    = 3;

   // Status data bit positions inside a flash status word.
   localparam int FHC_PRI_TOG_BIT = 6;
   localparam int FHC_SEC_TOG_BIT = 2;
   localparam int FHC_TMO_BIT     = 5;

   // Protect/unprotect address selection bits.
   localparam int FHC_PSEL_HI = 6;
   localparam int FHC_PSEL_MD = 1;
   localparam int FHC_PSEL_LO = 0;

   localparam logic [15:0] FHC_RESET_CMD = 16'h00f0;
   localparam logic [15:0] FHC_FLASH_RST_VAL = 16'h0000;

   // Times in their own units and the cycle counts at 40 ns per clock.
   localparam int CLK_NS        = 40;
   localparam int T_ACC_NS      = 55;
   localparam int T_WP_NS       = 35;
   localparam int T_WC_NS       = 55;
   localparam int T_OEH_NS      = 10;
   localparam int T_RP_NS       = 500;
   localparam int T_RH_NS       = 50;
   localparam int T_READY_US    = 20;
   localparam int T_RSP_US      = 4;
   localparam int T_BUSY_NS     = 30;
   localparam int T_ERASE_MS    = 1500;
   localparam int SYNC_STAGES   = 2;

   localparam logic [15:0] ACC_CYC   = 16'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RD_CYC    = 16'(ACC_CYC + SYNC_STAGES);
   localparam logic [15:0] WP_CYC    = 16'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] WC_CYC    = 16'((T_WC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] OEH_CYC   = 16'((T_OEH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] GAP_CYC   = (WC_CYC > OEH_CYC) ? WC_CYC : OEH_CYC;
   localparam logic [15:0] RP_CYC    = 16'((T_RP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RH_CYC    = 16'((T_RH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] READY_CYC = 32'((T_READY_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] VID_CYC   = 16'((T_RSP_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] BUSY_CYC  = 32'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
   localparam longint unsigned ERASE_MAX_CYC = 64'(T_ERASE_MS) * 64'd1000000 / 64'(CLK_NS);

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_SETUP   = 3'b001,
      ST_STROBE  = 3'b011,
      ST_HOLD    = 3'b010,
      ST_RST_LOW = 3'b110,
      ST_RST_REC = 3'b111,
      ST_WAIT    = 3'b101,
      ST_SPARE   = 3'b100
   } fhc_state_t;

   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_WRITE = 3'h1,
      OP_POLL  = 3'h2,
      OP_RESET = 3'h3,
      OP_WAIT  = 3'h4
   } fhc_op_t;
endpackage

`timescale 1ns/1ps

module fhc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // System clock.
   input  wire logic         rst_n, // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,     // Asynchronous pin levels.
   output logic      [W-1:0] q      // Levels after two flops.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fhc_sync_t;

   fhc_sync_t sync_reg;
   fhc_sync_t sync_next;

   // The first stage is read only by the second stage.
   always_comb begin
      sync_next    = sync_reg;
      sync_next.s1 = d;
      sync_next.s2 = sync_reg.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign q = sync_reg.s2;
endmodule // fhc_sync

`default_nettype wire

// ### fhc_ctrl.sv
// Flash host controller: APB registers in front of a parallel boot-sector flash pin sequencer.
//
// Overview of operation
// - Host waits at least 50 ns after reset release before reading.
// - Sector protect uses address bit6 low, bit1 high, bit0 low.
// - Sector unprotect uses address bit6 high, bit1 high, bit0 low.
// - Host may access at once when the done indicator shows ready.
// - Host holds elevated reset 4 us before a write in temporary unprotect.
// - Host keeps output enable high at least 10 ns between status reads.
// - After a timing-limit failure the host issues the reset command.
`timescale 1ns/1ps
`default_nettype none

module fhc_ctrl #(
   parameter logic [31:0] WAIT_LIMIT = 32'(fhc_pkg::ERASE_MAX_CYC) // Longest wait for ready.
) (
   input  wire logic        clk,            // System clock, 25 MHz.
   input  wire logic        rst_n,          // Asynchronous reset, active low.
   input  wire logic        psel,           // APB select.
   input  wire logic        penable,        // APB access phase.
   input  wire logic        pwrite,         // APB direction.
   input  wire logic [7:0]  paddr,          // APB byte address.
   input  wire logic [31:0] pwdata,         // APB write data.
   output logic      [31:0] prdata,         // APB read data.
   output logic             pready,         // APB ready.
   output logic             pslverr,        // APB error on unmapped address.
   output logic             irq,            // Level interrupt.
   output logic      [19:0] flash_addr,     // Flash address pins.
   output logic      [15:0] dq_o,           // Flash data out.
   output logic             dq_oe,          // Data pins driven when high.
   input  wire logic [15:0] dq_i,           // Flash data in.
   output logic             ce_n,           // Chip enable, active low.
   output logic             oe_n,           // Output enable, active low.
   output logic             we_n,           // Write enable, active low.
   output logic             flash_rst_n,    // Flash reset pin, active low.
   output logic             vid_en,         // Raise reset pin to unprotect voltage.
   input  wire logic        done_indicator  // Ready (high) or busy (low) pin.
);
   import fhc_pkg::*;

   typedef struct packed {
      fhc_state_t       st;
      fhc_op_t          op;
      logic             go;
      logic [15:0]      cnt;
      logic [31:0]      tmo;
      logic             first_rd;
      logic             prev_pri;
      logic             prev_to;
      logic             fail_wr;
      logic [19:0]      addr_reg;
      logic [15:0]      wdata_reg;
      logic [15:0]      rdata_reg;
      logic             prot_en;
      logic             unprot;
      logic             vid_req;
      logic [15:0]      vid_cnt;
      logic [FHC_IRQ_W-1:0] istat;
      logic [FHC_IRQ_W-1:0] imask;
      logic [19:0]      flash_addr;
      logic [15:0]      dq_o;
      logic             dq_oe;
      logic             ce_n;
      logic             oe_n;
      logic             we_n;
      logic             flash_rst_n;
      logic             vid_en;
      logic             irq;
      logic             pready;
      logic [31:0]      prdata;
      logic             pslverr;
   } fhc_ctrl_t;

   fhc_ctrl_t ctl_reg;
   fhc_ctrl_t ctl_next;

   logic [15:0] dq_s;
   logic        rdy_s;

   fhc_sync #(.W(17)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({done_indicator, dq_i}),
      .q     ({rdy_s, dq_s})
   );

   logic                 is_wr;
   logic                 vid_ok;
   logic                 mapped;
   logic                 acc;
   logic [FHC_IRQ_W-1:0] iset;
   logic [FHC_IRQ_W-1:0] iclr;
   logic [31:0]          rd_mux;
   logic [19:0]          sel_addr;

   always_comb begin
      ctl_next = ctl_reg;
      iset     = '0;
      iclr     = '0;
      is_wr    = (ctl_reg.op == OP_WRITE) || ctl_reg.fail_wr;
      vid_ok   = !ctl_reg.vid_req || (ctl_reg.vid_cnt == VID_CYC);
      sel_addr = ctl_reg.addr_reg;
      if (ctl_reg.prot_en) begin
         sel_addr[FHC_PSEL_HI] = ctl_reg.unprot;
         sel_addr[FHC_PSEL_MD] = 1'b1;
         sel_addr[FHC_PSEL_LO] = 1'b0;
      end

      // Elevated reset voltage must settle before an OP_WRITE is let through.
      ctl_next.vid_en = ctl_reg.vid_req;
      if (!ctl_reg.vid_req) begin
         ctl_next.vid_cnt = '0;
      end else if (ctl_reg.vid_cnt != VID_CYC) begin
         ctl_next.vid_cnt = ctl_reg.vid_cnt + 16'h0001;
      end

      ctl_next.cnt = ctl_reg.cnt + 16'h0001;
      case (ctl_reg.st)
         ST_IDLE: begin
            ctl_next.cnt = '0;
            ctl_next.tmo = '0;
            ctl_next.dq_oe = 1'b0;
            if (ctl_reg.go) begin
               case (ctl_reg.op)
                  OP_READ, OP_POLL: begin
                     ctl_next.go = 1'b0;
                     ctl_next.st = ST_SETUP;
                     ctl_next.first_rd = 1'b1;
                     ctl_next.flash_addr = sel_addr;
                     ctl_next.ce_n = 1'b0;
                  end
                  OP_WRITE: begin
                     if (vid_ok) begin
                        ctl_next.go = 1'b0;
                        ctl_next.st = ST_SETUP;
                        ctl_next.flash_addr = sel_addr;
                        ctl_next.dq_o = ctl_reg.wdata_reg;
                        ctl_next.dq_oe = 1'b1;
                        ctl_next.ce_n = 1'b0;
                     end
                  end
                  OP_RESET: begin
                     ctl_next.go = 1'b0;
                     ctl_next.st = ST_RST_LOW;
                     ctl_next.flash_rst_n = 1'b0;
                  end
                  OP_WAIT: begin
                     ctl_next.go = 1'b0;
                     ctl_next.st = ST_WAIT;
                  end
                  default: begin
                     ctl_next.go = 1'b0;
                  end
               endcase
            end
         end
         ST_SETUP: begin
            ctl_next.st = ST_STROBE;
            ctl_next.cnt = '0;
            ctl_next.we_n = !is_wr;
            ctl_next.oe_n = is_wr;
         end
         ST_STROBE: begin
            if (ctl_reg.cnt == (is_wr ? WP_CYC : RD_CYC) - 16'h0001) begin
               ctl_next.st = ST_HOLD;
               ctl_next.cnt = '0;
               ctl_next.we_n = 1'b1;
               ctl_next.oe_n = 1'b1;
               if (!is_wr) begin
                  ctl_next.rdata_reg = dq_s;
               end
            end
         end
         ST_HOLD: begin
            // Output enable stays high here, which spaces successive status reads.
            if (ctl_reg.cnt == GAP_CYC - 16'h0001) begin
               ctl_next.ce_n = 1'b1;
               ctl_next.dq_oe = 1'b0;
               ctl_next.st = ST_IDLE;
               if (ctl_reg.op == OP_POLL && !ctl_reg.fail_wr) begin
                  ctl_next.first_rd = 1'b0;
                  ctl_next.prev_pri = ctl_reg.rdata_reg[FHC_PRI_TOG_BIT];
                  ctl_next.prev_to = ctl_reg.rdata_reg[FHC_TMO_BIT];
                  // Only the primary flag is compared, so any address serves.
                  if (!ctl_reg.first_rd &&
                      ctl_reg.rdata_reg[FHC_PRI_TOG_BIT] == ctl_reg.prev_pri) begin
                     iset[FHC_IRQ_DONE] = 1'b1;
                  end else if (!ctl_reg.first_rd && ctl_reg.prev_to &&
                               ctl_reg.rdata_reg[FHC_TMO_BIT]) begin
                     ctl_next.fail_wr = 1'b1;
                     ctl_next.st = ST_SETUP;
                     ctl_next.flash_addr = FHC_FLASH_RST_VAL[3:0] == 4'h0 ? 20'h00000 : sel_addr;
                     ctl_next.dq_o = FHC_RESET_CMD;
                     ctl_next.dq_oe = 1'b1;
                     ctl_next.ce_n = 1'b0;
                  end else begin
                     ctl_next.st = ST_SETUP;
                     ctl_next.ce_n = 1'b0;
                  end
               end else if (ctl_reg.fail_wr) begin
                  ctl_next.fail_wr = 1'b0;
                  iset[FHC_IRQ_FAIL] = 1'b1;
               end else begin
                  iset[FHC_IRQ_DONE] = 1'b1;
               end
            end
         end
         ST_RST_LOW: begin
            ctl_next.tmo = ctl_reg.tmo + 32'h00000001;
            if (ctl_reg.cnt == RP_CYC - 16'h0001) begin
               ctl_next.flash_rst_n = 1'b1;
               ctl_next.st = ST_RST_REC;
               ctl_next.cnt = '0;
            end
         end
         ST_RST_REC: begin
            // Ready pin high ends the wait early; otherwise allow the full abort time.
            ctl_next.tmo = ctl_reg.tmo + 32'h00000001;
            if (ctl_reg.cnt >= RH_CYC - 16'h0001 &&
                (rdy_s || ctl_reg.tmo >= READY_CYC)) begin
               ctl_next.st = ST_IDLE;
               iset[FHC_IRQ_DONE] = 1'b1;
            end
         end
         ST_WAIT: begin
            ctl_next.tmo = ctl_reg.tmo + 32'h00000001;
            if (ctl_reg.tmo >= BUSY_CYC && rdy_s) begin
               ctl_next.st = ST_IDLE;
               iset[FHC_IRQ_DONE] = 1'b1;
            end else if (ctl_reg.tmo >= WAIT_LIMIT) begin
               ctl_next.st = ST_IDLE;
               iset[FHC_IRQ_TMO] = 1'b1;
            end
         end
         default: begin
            ctl_next.st = ST_IDLE;
         end
      endcase

      // APB slave: one wait state, then pready with registered data.
      mapped = (paddr[1:0] == 2'b00) && (paddr <= FHC_IMASK_OFS);
      acc = psel && penable && ctl_reg.pready;
      case (paddr)
         FHC_CTRL_OFS:   rd_mux = {25'h0, ctl_reg.vid_req, ctl_reg.unprot, ctl_reg.prot_en, ctl_reg.op, 1'b0};
         FHC_ADDR_OFS:   rd_mux = {12'h000, ctl_reg.addr_reg};
         FHC_WDATA_OFS:  rd_mux = {16'h0000, ctl_reg.wdata_reg};
         FHC_RDATA_OFS:  rd_mux = {16'h0000, ctl_reg.rdata_reg};
         FHC_STATUS_OFS: rd_mux = {28'h0000000, ctl_reg.flash_rst_n, vid_ok, rdy_s,
                                   (ctl_reg.st != ST_IDLE) || ctl_reg.go};
         FHC_ISTAT_OFS:  rd_mux = {29'h0, ctl_reg.istat};
         FHC_IMASK_OFS:  rd_mux = {29'h0, ctl_reg.imask};
         default:        rd_mux = 32'h00000000;
      endcase
      ctl_next.pready = psel && penable && !ctl_reg.pready;
      if (psel && penable && !ctl_reg.pready) begin
         ctl_next.prdata = pwrite ? 32'h00000000 : rd_mux;
         ctl_next.pslverr = !mapped;
      end
      if (acc && pwrite && mapped) begin
         case (paddr)
            FHC_CTRL_OFS: begin
               ctl_next.prot_en = pwdata[FHC_CTRL_PROT];
               ctl_next.unprot = pwdata[FHC_CTRL_UNPROT];
               ctl_next.vid_req = pwdata[FHC_CTRL_VID];
               // A start while busy is dropped.
               if (pwdata[FHC_CTRL_GO] && ctl_reg.st == ST_IDLE && !ctl_reg.go) begin
                  ctl_next.go = 1'b1;
                  ctl_next.op = fhc_op_t'(pwdata[FHC_CTRL_OP_LSB +: 3]);
               end
            end
            FHC_ADDR_OFS:  ctl_next.addr_reg = pwdata[19:0];
            FHC_WDATA_OFS: ctl_next.wdata_reg = pwdata[15:0];
            FHC_ISTAT_OFS: iclr = pwdata[FHC_IRQ_W-1:0];
            FHC_IMASK_OFS: ctl_next.imask = pwdata[FHC_IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // A new event beats a write-one clear in the same cycle.
      ctl_next.istat = (ctl_reg.istat & ~iclr) | iset;
      ctl_next.irq = |(ctl_next.istat & ctl_next.imask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= '0;
         ctl_reg.ce_n <= 1'b1;
         ctl_reg.oe_n <= 1'b1;
         ctl_reg.we_n <= 1'b1;
         ctl_reg.flash_rst_n <= 1'b1;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   assign prdata      = ctl_reg.prdata;
   assign pready      = ctl_reg.pready;
   assign pslverr     = ctl_reg.pslverr;
   assign irq         = ctl_reg.irq;
   assign flash_addr  = ctl_reg.flash_addr;
   assign dq_o        = ctl_reg.dq_o;
   assign dq_oe       = ctl_reg.dq_oe;
   assign ce_n        = ctl_reg.ce_n;
   assign oe_n        = ctl_reg.oe_n;
   assign we_n        = ctl_reg.we_n;
   assign flash_rst_n = ctl_reg.flash_rst_n;
   assign vid_en      = ctl_reg.vid_en;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   rst_release_gap_a: assert property ($rose(flash_rst_n) |-> ce_n [*2]) else $error("access too soon after reset");
   rst_pulse_a: assert property ($fell(flash_rst_n) |-> !flash_rst_n [*8]) else $error("reset pulse too short");
   prot_addr_a: assert property (!ce_n && ctl_reg.prot_en && !ctl_reg.unprot && !ctl_reg.fail_wr |->
      flash_addr[6] == 1'b0 && flash_addr[1] && !flash_addr[0]) else $error("bad protect address");
   unprot_addr_a: assert property (!ce_n && ctl_reg.prot_en && ctl_reg.unprot && !ctl_reg.fail_wr |->
      flash_addr[6] && flash_addr[1] && !flash_addr[0]) else $error("bad unprotect address");
   vid_setup_a: assert property (!we_n && vid_en |-> ctl_reg.vid_cnt == VID_CYC) else $error("write before unprotect setup");
   oe_gap_a: assert property ($rose(oe_n) |=> oe_n) else $error("output enable gap too short");
   fail_cmd_a: assert property ($rose(ctl_reg.fail_wr) |-> ##[1:4] (!we_n && dq_oe && dq_o == FHC_RESET_CMD))
      else $error("no reset command after failure");
   ready_go_a: assert property (ctl_reg.st == ST_WAIT && rdy_s && ctl_reg.tmo >= BUSY_CYC |=>
      ctl_reg.st == ST_IDLE && ctl_reg.istat[FHC_IRQ_DONE]) else $error("ready not acted on");

   read_done_c: cover property (ctl_reg.op == OP_READ && $rose(ctl_reg.istat[FHC_IRQ_DONE]));
   poll_fail_c: cover property ($rose(ctl_reg.istat[FHC_IRQ_FAIL]));
   reset_op_c: cover property (ctl_reg.st == ST_RST_REC ##1 ctl_reg.st == ST_IDLE);
endmodule // fhc_ctrl

`default_nettype wire

// ### fhc_flash_model.sv
// Behavioural model of the parallel flash device facing the host controller.
`timescale 1ns/1ps
`default_nettype none

module fhc_flash_model #(
   parameter int BUSY_NS = 4000 // Embedded algorithm length, shortened for simulation.
) (
   input  wire logic        ce_n,      // Chip enable, active low.
   input  wire logic        oe_n,      // Output enable, active low.
   input  wire logic        we_n,      // Write enable, active low.
   input  wire logic        rst_pin_n, // Reset pin, active low.
   input  wire logic [19:0] addr,      // Address pins.
   input  wire logic [15:0] din,       // Data from the host.
   output logic      [15:0] dout,      // Data to the host.
   output logic             ready      // Ready high, busy low.
);
   logic [19:0] last_addr = 20'h00000;
   logic [15:0] last_data = 16'h0000;
   logic        tog       = 1'b0;
   int          gen       = 0;
   int          tog_cnt   = 0;
   logic        stuck     = 1'b0;
   logic        standby   = 1'b0;
   time         fall_t    = 0;

   initial begin
      dout = 16'h0000;
      ready = 1'b1;
   end

   // A released bus shows the inverse of its last value, so a late sample never matches by luck.
   always @(posedge oe_n or posedge ce_n) dout = ~dout;

   always @(negedge oe_n) if (!ce_n) begin
      if (!ready) begin
         tog = ~tog;
         tog_cnt++;
      end
      dout = ready ? (addr[15:0] ^ 16'h5a5a) : {9'h000, tog, stuck, 2'h0, tog, 2'h0};
   end

   task automatic run_alg(input int my);
      #20 ready = 1'b0;
      #(BUSY_NS);
      // A failed algorithm stays busy until the reset command or a reset pin pulse arrives.
      if (gen == my && !stuck) ready = 1'b1;
   endtask

   // The reset command starts no algorithm and clears a stuck one; other commands taken while busy are ignored.
   always @(posedge we_n) if (!ce_n) begin
      last_addr = addr;
      last_data = din;
      if (din != 16'h00f0 && ready) begin
         gen++;
         fork
            run_alg(gen);
         join_none
      end else if (din == 16'h00f0 && stuck) begin
         gen++;
         stuck = 1'b0;
         ready = 1'b1;
      end
   end

   always @(negedge rst_pin_n) begin
      gen++;
      tog = 1'b0;
      stuck = 1'b0;
      fall_t = $time;
      #100 ready = 1'b1;
   end

   // Standby is reached only when the reset pin stayed low for the full entry time.
   always @(posedge rst_pin_n) standby = (($time - fall_t) >= 20000);
endmodule // fhc_flash_model

`default_nettype wire

// ### flash_reset_status_timing_bench.sv
// Self-checking testbench of the flash host controller over APB.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module flash_reset_status_timing_bench;
   import fhc_pkg::*;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] flash_addr;
   logic [15:0] dq_o, dq_i;
   logic        dq_oe, ce_n, oe_n, we_n, flash_rst_n, vid_en, done_indicator;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   fhc_ctrl #(.WAIT_LIMIT(32'd200)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe),
      .dq_i(dq_i), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .flash_rst_n(flash_rst_n),
      .vid_en(vid_en), .done_indicator(done_indicator));
   fhc_flash_model fm (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_pin_n(flash_rst_n),
      .addr(flash_addr), .din(dq_o), .dout(dq_i), .ready(done_indicator));

   always #20 clk = ~clk;

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      forever begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      `CHK(rd, exp)
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] flags, input fhc_op_t op);
      return {25'h0000000, flags, op, 1'b1};
   endfunction

   // Starts an operation, waits for its event, checks the interrupt, then clears the event.
   task automatic run_op(input logic [31:0] c, input logic [31:0] exp);
      wr(FHC_CTRL_OFS, c);
      rd = 32'h00000000;
      while (rd[2:0] === 3'b000) apb(1'b0, FHC_ISTAT_OFS, 32'h00000000);
      `CHK(rd, exp)
      `CHK(irq, 1'b1)
      wr(FHC_ISTAT_OFS, rd);
      rd_chk(FHC_ISTAT_OFS, 32'h00000000);
      `CHK(irq, 1'b0)
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(FHC_STATUS_OFS, 32'h0000000e);
      rd_chk(FHC_ISTAT_OFS, 32'h00000000);
      rd_chk(FHC_IMASK_OFS, 32'h00000000);
      rd_chk(FHC_CTRL_OFS, 32'h00000000);
      apb(1'b0, 8'h1c, 32'h00000000);
      `CHK(er, 1'b1)
      wr(FHC_IMASK_OFS, 32'h00000001);
      run_op(ctl(3'b000, OP_RESET), 32'h00000001);
      wr(FHC_ADDR_OFS, 32'h00012345);
      run_op(ctl(3'b000, OP_READ), 32'h00000001);
      rd_chk(FHC_RDATA_OFS, 32'h0000791f);
      wr(FHC_ADDR_OFS, 32'h00000abc);
      wr(FHC_WDATA_OFS, 32'h00001234);
      run_op(ctl(3'b000, OP_WRITE), 32'h00000001);
      `CHK(fm.last_data, 16'h1234)
      `CHK(done_indicator, 1'b0)
      run_op(ctl(3'b000, OP_POLL), 32'h00000001);
      `CHK(fm.tog_cnt > 1, 1'b1)
      `CHK(done_indicator, 1'b1)
      // Protect mode: pass 0 selects protect, pass 1 unprotect with the raised reset voltage.
      for (int i = 0; i < 2; i++) begin
         run_op(ctl({i[0], i[0], 1'b1}, OP_WRITE), 32'h00000001);
         `CHK({fm.last_addr[6], fm.last_addr[1:0]}, {i[0], 2'b10})
         `CHK(vid_en, i[0])
         run_op(ctl(3'b000, OP_WAIT), 32'h00000001);
         `CHK(done_indicator, 1'b1)
      end
      // A stuck program never shows ready: the wait times out, then polling sends the reset command.
      wr(FHC_IMASK_OFS, 32'h00000007);
      fm.stuck = 1'b1;
      run_op(ctl(3'b000, OP_WRITE), 32'h00000001);
      run_op(ctl(3'b000, OP_WAIT), 32'h00000004);
      run_op(ctl(3'b000, OP_POLL), 32'h00000002);
      `CHK({fm.last_addr, fm.last_data}, {20'h00000, FHC_RESET_CMD})
      `CHK(done_indicator, 1'b1)
      run_op(ctl(3'b000, OP_WRITE), 32'h00000001);
      `CHK(done_indicator, 1'b0)
      run_op(ctl(3'b000, OP_RESET), 32'h00000001);
      `CHK(done_indicator, 1'b1)
      `CHK(fm.standby, 1'b0)
      rd_chk(FHC_STATUS_OFS, 32'h0000000e);
      run_op(ctl(3'b000, OP_READ), 32'h00000001);
      rd_chk(FHC_RDATA_OFS, 32'h000050e6);
      wrap_up();
   end
endmodule // flash_reset_status_timing_bench

`default_nettype wire
